// File: rtl/sqp_regs.sv
// Purpose: Standby, sample queue, identity and offset registers of a motion sensor.
// Assumes: Serial front end issues register accesses on link_clk, one at a time.
// Notes:   Registers and queue live on clk; accesses cross by toggle handshake.
// Operation
// - Standby bit 7 lets the queue keep filling in low-power accel mode; resets 0.
// - Standby bits 5,4,3 put accel X, Y, Z into standby when set.
// - Queue byte count readable as high bits 1:0 and low bits 7:0.
// - Reading the high count register latches the count that the low count register returns.
// - Reading the data port pops a byte, writing it pushes a byte.
// - Each sample tick queues selected sensor bytes 59 to 72 in ascending order.
// - A sensor byte is queued only while its selection flag is set.
// - Overflow raises the queue overflow flag toward the status register.
// - With queue mode clear, overflow discards oldest bytes and keeps storing.
// - Reading an empty queue returns FF until new data arrives.
// - Queued bytes never hold FF, so FF means empty or queue access disabled.
// - Identity register returns a fixed eight-bit code.
// - Target address is 68 or 69 hex, low bit from the select pin.
// - Accel offsets are 15 bits: high register 14:7, low register 7:1.
// - Offsets apply in 0.98 mg steps over 16 g in every range.
// - Queue access from the serial side works only while enabled.
// - A queue reset request clears the queue for one internal clock period.
`timescale 1ns/10ps
module sqp_regs
(
    // System clock domain
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    // Link clock domain register access
    input  wire logic                  link_clk,
    input  wire logic                  link_rst,
    input  wire logic                  acc_req,
    input  wire sqp_pkg::sqp_access_t  acc_req_info,
    output logic                       acc_ready,
    output logic                       acc_done,
    output logic [7:0]                 acc_rdata,
    // Sensor sample source
    input  wire logic                  sample_tick,
    input  wire sqp_pkg::sqp_sensor_t  sensor_bytes,
    input  wire logic [13:0]           byte_select,
    input  wire logic                  accel_lowpower,
    // Queue control from the configuration and user-control registers
    input  wire logic                  queue_mode,
    input  wire logic                  queue_access_en,
    input  wire logic                  queue_reset_req,
    // Address select pin
    input  wire logic                  address_select_pin,
    // Outputs
    output sqp_pkg::sqp_standby_t      standby,
    output sqp_pkg::sqp_offset_t       offsets,
    output logic [6:0]                 target_addr,
    output logic                       queue_overflow_flag,
    output logic [9:0]                 queue_level
);
    import sqp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: hold one access stable until the system side acknowledges it.

    sqp_access_t hold_req;
    logic        link_busy;
    logic        req_tog;
    logic        ack_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic [7:0]  cross_rdata;

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tog;
            ack_s2 <= ack_s1;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            hold_req  <= '0;
            link_busy <= 1'b0;
            req_tog   <= 1'b0;
            ack_seen  <= 1'b0;
            acc_done  <= 1'b0;
            acc_rdata <= DATA_RESET;
        end
        else
        begin
            acc_done <= 1'b0;
            if (!link_busy && acc_req)
            begin
                hold_req  <= acc_req_info;
                req_tog   <= ~req_tog;
                link_busy <= 1'b1;
            end
            else if (link_busy && (ack_s2 != ack_seen))
            begin
                // Read data was registered on the same clk edge that toggled the acknowledge.
                ack_seen  <= ack_s2;
                link_busy <= 1'b0;
                acc_done  <= 1'b1;
                acc_rdata <= cross_rdata;
            end
        end
    end

    assign acc_ready = !link_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // System side: request synchroniser and pin synchroniser.

    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic sel_s1;
    logic sel_s2;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end
        else if (ce)
        begin
            req_s1 <= req_tog;
            req_s2 <= req_s1;
            sel_s1 <= address_select_pin;
            sel_s2 <= sel_s1;
        end
    end

    assign target_addr = {TARGET_ADDR_UPPER, sel_s2};

    ////////////////////////////////////////////////////////////////////////////////
    // Sample sequencer walks registers 59 to 72 after each tick.

    typedef enum logic [0:0] {SQP_SEQ_IDLE = 1'b0, SQP_SEQ_WALK = 1'b1} sqp_seq_t;

    sqp_seq_t    seq_state;
    logic [3:0]  seq_idx;
    sqp_sensor_t snap;
    logic [7:0]  standby_reg;
    logic        lp_block;

    // In low-power accel mode the queue stops unless standby bit 7 allows it.
    assign lp_block = accel_lowpower && !standby_reg[STBY_LP_BIT];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            seq_state <= SQP_SEQ_IDLE;
            seq_idx   <= 4'h0;
            snap      <= '0;
        end
        else if (ce)
        begin
            case (seq_state)
                SQP_SEQ_IDLE:
                begin
                    if (sample_tick && !lp_block)
                    begin
                        snap      <= sensor_bytes;
                        seq_idx   <= 4'h0;
                        seq_state <= SQP_SEQ_WALK;
                    end
                end
                SQP_SEQ_WALK:
                begin
                    if (seq_idx == SEQ_LAST)
                        seq_state <= SQP_SEQ_IDLE;
                    else
                        seq_idx <= seq_idx + 4'h1;
                end
                default:
                    seq_state <= SQP_SEQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access execution and queue control.

    logic [7:0]  queue_mem [512];
    logic [8:0]  wr_ptr;
    logic [8:0]  rd_ptr;
    logic [9:0]  count;
    logic [12:0] level_latch;
    logic [3:0]  qrst_cnt;
    logic        flushing;
    logic        pend;
    logic        do_acc;
    logic        data_hit;
    logic        host_pop;
    logic        host_push;
    logic        sens_push;
    logic        push;
    logic        full;
    logic        empty;
    logic        drop;
    logic [7:0]  raw_data;
    logic [7:0]  push_data;
    logic [7:0]  read_val;
    logic [14:0] off_x;
    logic [14:0] off_y;
    logic [14:0] off_z;

    assign flushing  = (qrst_cnt != 4'h0);
    assign pend      = (req_s2 != req_seen);
    // Accesses wait while the sequencer pushes, so only one push per cycle.
    assign do_acc    = ce && pend && (seq_state == SQP_SEQ_IDLE) && !flushing;
    assign data_hit  = (hold_req.addr == ADDR_DATA_PORT) && queue_access_en;
    assign host_pop  = do_acc && !hold_req.write && data_hit;
    assign host_push = do_acc && hold_req.write && data_hit;
    assign sens_push = ce && (seq_state == SQP_SEQ_WALK) && byte_select[seq_idx];
    assign push      = host_push || sens_push;
    assign full      = (count == QUEUE_FULL);
    assign empty     = (count == 10'h000);
    assign drop      = push && full && queue_mode;
    assign raw_data  = sens_push ? snap[seq_idx] : hold_req.wdata;
    assign push_data = (raw_data == EMPTY_MARK) ? CLAMPED_MARK : raw_data;
    assign queue_level = count;

    // Read multiplexer; unmapped registers read as zero.
    always_comb
    begin
        read_val = 8'h00;
        if (hold_req.addr == ADDR_STANDBY)
            read_val = standby_reg;
        else if (hold_req.addr == ADDR_LEVEL_HIGH)
            read_val = {6'h00, count[9:8]};
        else if (hold_req.addr == ADDR_LEVEL_LOW)
            read_val = level_latch[7:0];
        else if (hold_req.addr == ADDR_DATA_PORT)
            read_val = (empty || !queue_access_en) ? EMPTY_MARK : queue_mem[rd_ptr];
        else if (hold_req.addr == ADDR_IDENTITY)
            read_val = IDENTITY_CODE;
        else if (hold_req.addr == ADDR_ACC_X_HIGH)
            read_val = off_x[14:7];
        else if (hold_req.addr == ADDR_ACC_X_LOW)
            read_val = {off_x[6:0], 1'b0};
        else if (hold_req.addr == ADDR_ACC_Y_HIGH)
            read_val = off_y[14:7];
        else if (hold_req.addr == ADDR_ACC_Y_LOW)
            read_val = {off_y[6:0], 1'b0};
        else if (hold_req.addr == ADDR_ACC_Z_HIGH)
            read_val = off_z[14:7];
        else if (hold_req.addr == ADDR_ACC_Z_LOW)
            read_val = {off_z[6:0], 1'b0};
    end

    // Handshake back to the link side.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            req_seen    <= 1'b0;
            ack_tog     <= 1'b0;
            cross_rdata <= DATA_RESET;
        end
        else if (do_acc)
        begin
            req_seen    <= req_s2;
            ack_tog     <= ~ack_tog;
            cross_rdata <= hold_req.write ? DATA_RESET : read_val;
        end
    end

    // Count latch: the high read captures the whole level, the low read reuses it.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            level_latch <= 13'h0000;
        else if (do_acc && !hold_req.write && (hold_req.addr == ADDR_LEVEL_HIGH))
            level_latch <= {3'h0, count};
    end

    // Control registers written by the host.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            standby_reg <= STANDBY_RESET;
            off_x       <= OFFSET_RESET;
            off_y       <= OFFSET_RESET;
            off_z       <= OFFSET_RESET;
        end
        else if (do_acc && hold_req.write)
        begin
            if (hold_req.addr == ADDR_STANDBY)
                standby_reg <= hold_req.wdata & STBY_WR_MASK;
            else if (hold_req.addr == ADDR_ACC_X_HIGH)
                off_x[14:7] <= hold_req.wdata;
            else if (hold_req.addr == ADDR_ACC_X_LOW)
                off_x[6:0] <= hold_req.wdata[7:1];
            else if (hold_req.addr == ADDR_ACC_Y_HIGH)
                off_y[14:7] <= hold_req.wdata;
            else if (hold_req.addr == ADDR_ACC_Y_LOW)
                off_y[6:0] <= hold_req.wdata[7:1];
            else if (hold_req.addr == ADDR_ACC_Z_HIGH)
                off_z[14:7] <= hold_req.wdata;
            else if (hold_req.addr == ADDR_ACC_Z_LOW)
                off_z[6:0] <= hold_req.wdata[7:1];
        end
    end

    assign standby.queue_in_lowpower_accel = standby_reg[STBY_LP_BIT];
    assign standby.accel_x_standby         = standby_reg[STBY_ACC_X];
    assign standby.accel_y_standby         = standby_reg[STBY_ACC_Y];
    assign standby.accel_z_standby         = standby_reg[STBY_ACC_Z];
    assign standby.gyro_x_standby          = standby_reg[STBY_GYR_X];
    assign standby.gyro_y_standby          = standby_reg[STBY_GYR_Y];
    assign standby.gyro_z_standby          = standby_reg[STBY_GYR_Z];
    // Offsets are passed on as raw step codes; scaling is fixed in the datapath.
    assign offsets = {off_x, off_y, off_z};

    // Queue reset is stretched over one internal-clock period. The reset is taken
    // synchronously here, which costs one cycle against a true asynchronous clear.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            qrst_cnt <= 4'h0;
        else if (ce)
        begin
            if (queue_reset_req)
                qrst_cnt <= QRST_LOAD;
            else if (flushing)
                qrst_cnt <= qrst_cnt - 4'h1;
        end
    end

    // Queue pointers and level.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            count  <= 10'h000;
        end
        else if (ce)
        begin
            // A running queue reset also waits on the clock enable.
            if (flushing)
            begin
                wr_ptr <= 9'h000;
                rd_ptr <= 9'h000;
                count  <= 10'h000;
            end
            else if (push && !drop)
            begin
                wr_ptr <= wr_ptr + 9'h001;
                if (full)
                    rd_ptr <= rd_ptr + 9'h001;
                else
                    count <= count + 10'h001;
            end
            else if (host_pop && !empty)
            begin
                rd_ptr <= rd_ptr + 9'h001;
                count  <= count - 10'h001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && push && !drop && !flushing)
            queue_mem[wr_ptr] <= push_data;
    end

    // Overflow pulse toward the interrupt status register.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            queue_overflow_flag <= 1'b0;
        else if (ce)
            queue_overflow_flag <= push && full && !flushing;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_empty_read_mark: assert property (
        host_pop && empty |=> cross_rdata == 8'hFF)
        else $error("Empty queue read did not return FF.");

    a_count_up: assert property (
        push && !full && !flushing |=> count == $past(count) + 10'h001)
        else $error("Stored byte did not raise the count.");

    a_count_down: assert property (
        host_pop && !empty && !flushing |=> count == $past(count) - 10'h001)
        else $error("Popped byte did not lower the count.");

    a_overflow_pulse: assert property (
        push && full && !flushing |=> queue_overflow_flag)
        else $error("Overflow flag missing after push into full queue.");

    a_keep_old_full: assert property (
        drop && !flushing |=> count == QUEUE_FULL && $stable(wr_ptr) && $stable(rd_ptr))
        else $error("Full queue in keep mode lost old data.");

    a_drop_oldest: assert property (
        push && full && !queue_mode && !flushing |=> count == QUEUE_FULL
            && rd_ptr == $past(rd_ptr) + 9'h001)
        else $error("Full queue in stream mode did not discard oldest byte.");

    a_never_mark: assert property (
        push && !drop && !flushing |=> queue_mem[$past(wr_ptr)] != 8'hFF)
        else $error("Queued byte holds the empty mark.");

    a_level_latch: assert property (
        do_acc && !hold_req.write && hold_req.addr == ADDR_LEVEL_HIGH
            |=> level_latch[9:0] == $past(count) ##1 $stable(level_latch))
        else $error("High count read did not latch the level.");

    a_lowpower_gate: assert property (
        ce && seq_state == SQP_SEQ_IDLE && lp_block |=> seq_state == SQP_SEQ_IDLE)
        else $error("Sequencer started while blocked in low-power mode.");

    a_flush_length: assert property (
        ce && queue_reset_req |=> flushing [*8] ##0 count == 10'h000)
        else $error("Queue reset too short or level not cleared.");

    a_seq_order: assert property (
        ce && seq_state == SQP_SEQ_WALK && seq_idx != SEQ_LAST
            |=> seq_state == SQP_SEQ_WALK && seq_idx == $past(seq_idx) + 4'h1)
        else $error("Sample bytes not walked in ascending order.");

endmodule

// File: include/sqp_pkg.sv
// Purpose: Shared constants and carrier types for the sensor queue register bank.
// Assumes: Registers are addressed by a 7-bit register number from the serial front end.
// Notes:   Register offsets, standby field positions, control register reset values and the queue reset timing live here.
package sqp_pkg;

    // Register numbers.
    localparam logic [6:0] ADDR_STANDBY     = 7'h6C;
    localparam logic [6:0] ADDR_LEVEL_HIGH  = 7'h72;
    localparam logic [6:0] ADDR_LEVEL_LOW   = 7'h73;
    localparam logic [6:0] ADDR_DATA_PORT   = 7'h74;
    localparam logic [6:0] ADDR_IDENTITY    = 7'h75;
    localparam logic [6:0] ADDR_ACC_X_HIGH  = 7'h77;
    localparam logic [6:0] ADDR_ACC_X_LOW   = 7'h78;
    localparam logic [6:0] ADDR_ACC_Y_HIGH  = 7'h7A;
    localparam logic [6:0] ADDR_ACC_Y_LOW   = 7'h7B;
    localparam logic [6:0] ADDR_ACC_Z_HIGH  = 7'h7D;
    localparam logic [6:0] ADDR_ACC_Z_LOW   = 7'h7E;

    // Standby-control field positions.
    localparam int STBY_LP_BIT   = 7;
    localparam int STBY_ACC_X    = 5;
    localparam int STBY_ACC_Y    = 4;
    localparam int STBY_ACC_Z    = 3;
    localparam int STBY_GYR_X    = 2;
    localparam int STBY_GYR_Y    = 1;
    localparam int STBY_GYR_Z    = 0;
    localparam logic [7:0] STBY_WR_MASK = 8'hBF;

    // Reset values.
    localparam logic [7:0]  STANDBY_RESET = 8'h00;
    localparam logic [14:0] OFFSET_RESET  = 15'h0000;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    // Identity code; the value is arbitrary.
    localparam logic [7:0] IDENTITY_CODE = 8'h5A;

    // Target address: upper six bits fixed, lowest bit from the select pin.
    localparam logic [5:0] TARGET_ADDR_UPPER = 6'h34;

    // Queue geometry and markers.
    localparam logic [9:0] QUEUE_FULL     = 10'h200;
    localparam logic [7:0] EMPTY_MARK     = 8'hFF;
    localparam logic [7:0] CLAMPED_MARK   = 8'hFE;
    localparam logic [3:0] SEQ_LAST       = 4'hD;
    localparam int         LEVEL_HIGH_MSB = 12;

    // Queue reset lasts one period of the 20 MHz internal clock.
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int QRST_PERIOD_PS    = 50000;
    localparam int QRST_CYCLES       = (QRST_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] QRST_LOAD = 4'(QRST_CYCLES);

    // One register access as carried across the clock crossing.
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } sqp_access_t;

    // Sensor data registers 59 to 72, element 0 is register 59.
    typedef logic [13:0][7:0] sqp_sensor_t;

    // Standby outputs: low-power queue bit and per-axis standby bits.
    typedef struct packed {
        logic queue_in_lowpower_accel;
        logic accel_x_standby;
        logic accel_y_standby;
        logic accel_z_standby;
        logic gyro_x_standby;
        logic gyro_y_standby;
        logic gyro_z_standby;
    } sqp_standby_t;

    // Offset-cancellation values, 0.98 mg per step over +/-16 g.
    typedef struct packed {
        logic [14:0] accel_x_offset_value;
        logic [14:0] accel_y_offset_value;
        logic [14:0] accel_z_offset_value;
    } sqp_offset_t;

endpackage

// File: test/sqp_host_model.sv
// Purpose: Host side of the register link, one access at a time.
// Assumes: Link signals change just after a rising edge of link_clk.
// Notes:   Request info is scrambled once the request drops.
`timescale 1ns/10ps
module sqp_host_model
(
    // Register link
    input  wire logic           link_clk,
    input  wire logic           acc_ready,
    input  wire logic           acc_done,
    input  wire logic [7:0]     acc_rdata,
    output logic                acc_req,
    output sqp_pkg::sqp_access_t acc_req_info
);
    import sqp_pkg::*;
    initial
    begin
        acc_req = 1'b0;
        acc_req_info = 16'hA5C3;
    end
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] r);
        int n;
        n = 0;
        r = 8'hXX;
        @(posedge link_clk);
        #1;
        acc_req = 1'b1;
        acc_req_info = {w, a, d};
        @(posedge link_clk);
        #1;
        acc_req = 1'b0;
        acc_req_info = ~acc_req_info;
        while (n < 400)
        begin
            @(posedge link_clk);
            n++;
            if (acc_done === 1'b1)
            begin
                r = acc_rdata;
                break;
            end
        end
    endtask
endmodule

// File: test/sqp_regs_test.sv
// Purpose: Self-checking bench for the sensor queue register bank.
// Assumes: The host model carries every register access.
// Notes:   Long fills use the sample path, since host pops are slow.
`timescale 1ns/10ps
module sqp_regs_test;
    import sqp_pkg::*;
    logic         clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, link_rst = 1'b1;
    logic         sample_tick = 1'b0, accel_lowpower = 1'b0, queue_mode = 1'b0;
    logic         queue_access_en = 1'b1, queue_reset_req = 1'b0, pin = 1'b0;
    logic         acc_req, acc_ready, acc_done, ovf;
    logic [7:0]   acc_rdata, r, stb, h, l, d;
    logic [13:0]  byte_select = 14'h0000;
    logic [44:0]  exp_off;
    logic [6:0]   target_addr;
    logic [9:0]   queue_level;
    sqp_sensor_t  sensor_bytes = '0;
    sqp_access_t  info;
    sqp_standby_t standby;
    sqp_offset_t  offsets;
    logic [7:0]   q[$];
    int           num_errors = 0, n_tests = 0, ovf_seen = 0, seed;
    always #2.5 clk = ~clk;
    initial #1.3 forever #62.5 link_clk = ~link_clk;
    always @(posedge clk) if (ovf === 1'b1) ovf_seen++;
    sqp_host_model host (.link_clk(link_clk), .acc_ready(acc_ready), .acc_done(acc_done),
        .acc_rdata(acc_rdata), .acc_req(acc_req), .acc_req_info(info));
    sqp_regs uut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .link_clk(link_clk),
        .link_rst(link_rst), .acc_req(acc_req), .acc_req_info(info), .acc_ready(acc_ready),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .sample_tick(sample_tick),
        .sensor_bytes(sensor_bytes), .byte_select(byte_select),
        .accel_lowpower(accel_lowpower), .queue_mode(queue_mode),
        .queue_access_en(queue_access_en), .queue_reset_req(queue_reset_req),
        .address_select_pin(pin), .standby(standby), .offsets(offsets),
        .target_addr(target_addr), .queue_overflow_flag(ovf), .queue_level(queue_level));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer(1'b1, a, v, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input string m);
        host.xfer(1'b0, a, 8'h00, r);
        chk(48'(r), 48'(e), m);
        chk(48'(acc_ready), 48'h1, "ready after done");
    endtask
    // Full queue: mode clear drops the oldest byte, mode set drops the new one.
    function automatic void push(input logic [7:0] b);
        logic [7:0] c;
        c = (b == EMPTY_MARK) ? CLAMPED_MARK : b;
        if (q.size() < 512)
            q.push_back(c);
        else if (!queue_mode)
        begin
            void'(q.pop_front());
            q.push_back(c);
        end
    endfunction
    task automatic lvl;
        rd(ADDR_LEVEL_HIGH, 8'(q.size() >> 8), "level high");
        rd(ADDR_LEVEL_LOW, 8'(q.size()), "level low");
        chk(48'(queue_level), 48'(q.size()), "live level");
    endtask
    task automatic drain;
        while (q.size() > 0)
            rd(ADDR_DATA_PORT, q.pop_front(), "pop");
        rd(ADDR_DATA_PORT, EMPTY_MARK, "empty again");
    endtask
    task automatic tick(input logic [13:0] sel, input logic ff);
        @(posedge clk);
        #1;
        byte_select = sel;
        for (int i = 0; i < 14; i++)
            sensor_bytes[i] = 8'($urandom);
        if (ff)
            sensor_bytes[3] = 8'hFF;
        sample_tick = 1'b1;
        @(posedge clk);
        #1;
        sample_tick = 1'b0;
        if (!(accel_lowpower && !stb[7]))
            for (int i = 0; i < 14; i++)
                if (sel[i])
                    push(sensor_bytes[i]);
        repeat (16) @(posedge clk);
    endtask
    task automatic qclr;
        @(posedge clk);
        #1;
        queue_reset_req = 1'b1;
        @(posedge clk);
        #1;
        queue_reset_req = 1'b0;
        repeat (12) @(posedge clk);
        q.delete();
        chk(48'(queue_level), 48'h0, "queue reset");
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        seed = $urandom(32'h8d15);
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge link_clk);
        #1;
        link_rst = 1'b0;
        rd(ADDR_STANDBY, STANDBY_RESET, "standby reset");
        wr(ADDR_IDENTITY, 8'h00);
        rd(ADDR_IDENTITY, IDENTITY_CODE, "identity");
        rd(7'h70, 8'h00, "unmapped");
        chk(48'(target_addr), 48'h68, "address pin low");
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            stb = (k == 0) ? 8'hFF : 8'($urandom);
            wr(ADDR_STANDBY, stb);
            rd(ADDR_STANDBY, stb & STBY_WR_MASK, "standby");
            chk(48'(standby), 48'({stb[7], stb[5:0]}), "standby out");
        end
        for (int k = 0; k < 3; k++)
        begin
            h = 8'($urandom);
            l = 8'($urandom) | 8'h01;
            wr(ADDR_ACC_X_HIGH + 7'(3 * k), h);
            wr(ADDR_ACC_X_LOW + 7'(3 * k), l);
            rd(ADDR_ACC_X_LOW + 7'(3 * k), l & 8'hFE, "offset low");
            rd(ADDR_ACC_X_HIGH + 7'(3 * k), h, "offset high");
            exp_off[44 - 15 * k -: 15] = {h, l[7:1]};
        end
        chk(48'(offsets), 48'(exp_off), "offsets");
        $display("test standby and offsets done");
        rd(ADDR_DATA_PORT, EMPTY_MARK, "empty");
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? 8'hFF : 8'($urandom);
            wr(ADDR_DATA_PORT, d);
            push(d);
        end
        lvl();
        rd(ADDR_LEVEL_HIGH, 8'h00, "high latch");
        wr(ADDR_DATA_PORT, 8'h11);
        rd(ADDR_LEVEL_LOW, 8'h03, "low held");
        push(8'h11);
        queue_access_en = 1'b0;
        rd(ADDR_DATA_PORT, EMPTY_MARK, "disabled pop");
        wr(ADDR_DATA_PORT, 8'h22);
        queue_access_en = 1'b1;
        lvl();
        drain();
        $display("test host queue done");
        stb = 8'h00;
        wr(ADDR_STANDBY, stb);
        accel_lowpower = 1'b1;
        tick(14'h3FFF, 1'b0);
        stb = 8'h80;
        wr(ADDR_STANDBY, stb);
        tick(14'($urandom), 1'b1);
        accel_lowpower = 1'b0;
        tick(14'($urandom), 1'b0);
        lvl();
        drain();
        $display("test sample stream done");
        for (int m = 0; m < 2; m++)
        begin
            queue_mode = m[0];
            ovf_seen = 0;
            repeat (37) tick(14'h3FFF, 1'b0);
            chk(48'(ovf_seen), 48'd6, "overflow pulses");
            lvl();
            repeat (3) rd(ADDR_DATA_PORT, q.pop_front(), "kept");
            qclr();
        end
        $display("test overflow done");
        pin = 1'b1;
        repeat (4) @(posedge clk);
        chk(48'(target_addr), 48'h69, "address pin high");
        $display("test address done");
        wrap_up();
    end
endmodule
